/* ohbi_pkg.sv */
// Constants and types shared by the host bus interface of the display module.
// How it works
// - Four bus modes: 8080, 6800, 3-wire, 4-wire.
// - 6800 mode: read_not_write low writes, high reads.
// - cmd_or_data_sel low: command/status; high: display data.
// - 6800 transfers finish at latch_clk fall, chip selected.
// - 8080 mode uses separate read and write strobes.
// - 8080 read ends at read_strobe_n rise; device drives.
// - 8080 write captured at write_strobe_n rise.
// - First data read after column address is dummy.
// - Serial: bit 0 clock, bit 1 data.
// - 4-wire samples on rising serial clock, selected.
// - Serial modes carry writes only, no reads.
// - hard_init_n low resets all but the pin synchronisers and FIFO storage.
`default_nettype none

package ohbi_pkg;

  // Bus mode strap codes.
  typedef enum logic [1:0] {
    OHBI_MODE_8080 = 2'b00,
    OHBI_MODE_6800 = 2'b01,
    OHBI_MODE_SPI3 = 2'b10,
    OHBI_MODE_SPI4 = 2'b11
  } ohbi_mode_type;

  // One accepted write: selector bit and payload byte.
  typedef struct packed {
    logic       is_data;
    logic [7:0] value;
  } ohbi_word_type;

  // Every pin that comes from the host, sampled as one group.
  typedef struct packed {
    logic          hard_init_n;
    logic [1:0]    mode;
    logic          strobe_a;   // latch_clk (6800) or read_strobe_n (8080).
    logic          strobe_b;   // read_not_write (6800) or write_strobe_n.
    logic          cmd_or_data_sel;
    logic          chip_sel_n;
    logic [7:0]    db;
  } ohbi_pins_type;

  localparam int          OHBI_WORD_W     = 9;
  localparam int          OHBI_FIFO_DEPTH = 16;
  localparam int          OHBI_CNT_W      = 4;
  localparam logic [3:0]  OHBI_SPI4_LAST  = 4'h7;
  localparam logic [3:0]  OHBI_SPI3_LAST  = 4'h8;
  localparam int          OHBI_SCLK_BIT   = 0;
  localparam int          OHBI_SERIAL_IN_LINE_BIT   = 1;
  localparam logic [7:0]  OHBI_BYTE_RST   = 8'h00;
  localparam logic [3:0]  OHBI_CNT_RST    = 4'h0;
  // Idle pin levels: strobes and selects inactive, held in init.
  localparam logic [14:0] OHBI_PINS_RST   = 15'h0d00;

endpackage : ohbi_pkg

`default_nettype wire

/* ohbi_top.sv */
// Host bus interface: write FIFO and the bus decoder for all four modes.
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// Write FIFO with valid/ready on both sides.
module ohbi_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 16
) (
  input  wire logic             ref_clk,
  input  wire logic             reset_n,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW:0]      wr_ptr_reg;
  logic [AW:0]      rd_ptr_reg;
  logic             push;
  logic             pop;

  // Extra pointer bit tells full from empty.
  assign out_valid = wr_ptr_reg != rd_ptr_reg;
  assign in_ready  = (wr_ptr_reg[AW] == rd_ptr_reg[AW])
                   || (wr_ptr_reg[AW-1:0] != rd_ptr_reg[AW-1:0]);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem_reg[rd_ptr_reg[AW-1:0]];

  // Storage is written only, never reset, to keep it plain flops.
  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem_reg[wr_ptr_reg[AW-1:0]] <= in_data;
    end
  end

  // Pointers.
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
    end
  end
endmodule : ohbi_fifo

////////////////////////////////////////////////////////////////////////////////
// Device end of the host bus.
module ohbi_top (
  input  wire logic                   ref_clk,
  input  wire logic                   reset_n,
  input  wire logic                   hard_init_n,
  input  wire logic [1:0]             bus_mode,
  input  wire logic                   latch_clk_or_read_strobe_n,
  input  wire logic                   read_not_write_or_write_strobe_n,
  input  wire logic                   cmd_or_data_sel,
  input  wire logic                   chip_sel_n,
  input  wire logic [7:0]             db_in,
  output logic      [7:0]             db_out,
  output logic                        db_oe,
  input  wire logic [7:0]             status_in,
  input  wire logic [7:0]             ram_data_in,
  input  wire logic                   col_addr_written,
  output logic                        ram_next,
  output logic                        wr_valid,
  input  wire logic                   wr_ready,
  output ohbi_pkg::ohbi_word_type     wr_word,
  output logic                        bus_ready,
  output logic                        overflow,
  output logic                        init_active
);

  ohbi_pkg::ohbi_pins_type pins_raw;
  ohbi_pkg::ohbi_pins_type s1_reg;
  ohbi_pkg::ohbi_pins_type s2_reg;
  ohbi_pkg::ohbi_pins_type prev_reg;
  ohbi_pkg::ohbi_mode_type mode;
  ohbi_pkg::ohbi_word_type push_word_reg;
  ohbi_pkg::ohbi_word_type par_word;
  ohbi_pkg::ohbi_word_type ser_word;
  logic                    init;
  logic                    selected;
  logic                    par_write;
  logic                    par_read_end;
  logic                    read_drive;
  logic                    ser_rise;
  logic                    ser_done;
  logic                    push_reg;
  logic                    fifo_ready;
  logic [7:0]              shift_reg;
  logic [3:0]              cnt_reg;
  logic [7:0]              read_latch_reg;
  logic                    dummy_reg;
  logic [7:0]              db_out_reg;
  logic                    db_oe_reg;
  logic                    ram_next_reg;
  logic                    overflow_reg;

  assign pins_raw = '{hard_init_n:     hard_init_n,
                      mode:            bus_mode,
                      strobe_a:        latch_clk_or_read_strobe_n,
                      strobe_b:        read_not_write_or_write_strobe_n,
                      cmd_or_data_sel: cmd_or_data_sel,
                      chip_sel_n:      chip_sel_n,
                      db:              db_in};

  //////////////////////////////////////////////////////////////////////////////
  // Two-stage synchroniser for every host pin, then an edge history stage.
  // Only the system reset clears it, so hard_init_n can be seen leaving.
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      s1_reg   <= ohbi_pkg::OHBI_PINS_RST;
      s2_reg   <= ohbi_pkg::OHBI_PINS_RST;
      prev_reg <= ohbi_pkg::OHBI_PINS_RST;
    end else begin
      s1_reg   <= pins_raw;
      s2_reg   <= s1_reg;
      prev_reg <= s2_reg;
    end
  end

  // Hardware initialization holds everything else in reset except the FIFO storage.
  assign init        = !reset_n || !s2_reg.hard_init_n;
  assign init_active = init;
  assign mode        = ohbi_pkg::ohbi_mode_type'(s2_reg.mode);
  // History holds reset levels for one cycle after reset; no edge is read
  // then, so a strobe idling at the other level cannot fake a transfer.
  assign selected    = !s2_reg.chip_sel_n && prev_reg.hard_init_n;

  //////////////////////////////////////////////////////////////////////////////
  // Parallel strobe decoding.
  always_comb begin
    par_write    = 1'b0;
    par_read_end = 1'b0;
    read_drive   = 1'b0;
    unique case (mode)
      ohbi_pkg::OHBI_MODE_8080: begin
        // Write latches on write_strobe_n rise with read strobe idle.
        par_write    = selected && !prev_reg.strobe_b && s2_reg.strobe_b
                     && s2_reg.strobe_a;
        par_read_end = selected && !prev_reg.strobe_a && s2_reg.strobe_a
                     && s2_reg.strobe_b;
        read_drive   = selected && !s2_reg.strobe_a && s2_reg.strobe_b;
      end
      ohbi_pkg::OHBI_MODE_6800: begin
        // Everything completes on the falling edge of latch_clk.
        par_write    = selected && prev_reg.strobe_a && !s2_reg.strobe_a
                     && !s2_reg.strobe_b;
        par_read_end = selected && prev_reg.strobe_a && !s2_reg.strobe_a
                     && s2_reg.strobe_b;
        read_drive   = selected && s2_reg.strobe_a && s2_reg.strobe_b;
      end
      ohbi_pkg::OHBI_MODE_SPI3, ohbi_pkg::OHBI_MODE_SPI4: begin
        // No read path and no parallel writes in serial modes.
        par_write    = 1'b0;
        par_read_end = 1'b0;
        read_drive   = 1'b0;
      end
    endcase
  end

  assign par_word = '{is_data: s2_reg.cmd_or_data_sel,
                      value:   s2_reg.db};

  //////////////////////////////////////////////////////////////////////////////
  // Serial shifter: bit 0 is the clock, bit 1 the data.
  assign ser_rise = (mode == ohbi_pkg::OHBI_MODE_SPI3
                     || mode == ohbi_pkg::OHBI_MODE_SPI4)
                  && selected
                  && !prev_reg.db[ohbi_pkg::OHBI_SCLK_BIT]
                  && s2_reg.db[ohbi_pkg::OHBI_SCLK_BIT];
  assign ser_done = ser_rise
                  && (mode == ohbi_pkg::OHBI_MODE_SPI4
                      ? cnt_reg == ohbi_pkg::OHBI_SPI4_LAST
                      : cnt_reg == ohbi_pkg::OHBI_SPI3_LAST);

  // In 3-wire mode the selector bit sits at shift_reg[7] by the last bit.
  always_comb begin
    if (mode == ohbi_pkg::OHBI_MODE_SPI4) begin
      ser_word = '{is_data: s2_reg.cmd_or_data_sel,
                   value:   {shift_reg[6:0],
                             s2_reg.db[ohbi_pkg::OHBI_SERIAL_IN_LINE_BIT]}};
    end else begin
      ser_word = '{is_data: shift_reg[7],
                   value:   {shift_reg[6:0],
                             s2_reg.db[ohbi_pkg::OHBI_SERIAL_IN_LINE_BIT]}};
    end
  end

  // Deselecting aborts a partial frame so the next one starts aligned.
  always_ff @(posedge ref_clk) begin
    if (init || !selected) begin
      cnt_reg   <= ohbi_pkg::OHBI_CNT_RST;
      shift_reg <= ohbi_pkg::OHBI_BYTE_RST;
    end else if (ser_rise) begin
      shift_reg <= {shift_reg[6:0], s2_reg.db[ohbi_pkg::OHBI_SERIAL_IN_LINE_BIT]};
      cnt_reg   <= ser_done ? ohbi_pkg::OHBI_CNT_RST : cnt_reg + 4'h1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Accepted writes are staged one cycle, then offered to the FIFO.
  // The host cannot be stalled mid-strobe, so a write that meets a full
  // FIFO is lost and flagged; bus_ready lets the host pace itself.
  always_ff @(posedge ref_clk) begin
    if (init) begin
      push_reg      <= 1'b0;
      push_word_reg <= '0;
    end else begin
      push_reg      <= par_write || ser_done;
      push_word_reg <= par_write ? par_word : ser_word;
    end
  end

  // Sticky overflow flag.
  always_ff @(posedge ref_clk) begin
    if (init) begin
      overflow_reg <= 1'b0;
    end else if (push_reg && !fifo_ready) begin
      overflow_reg <= 1'b1;
    end
  end

  ohbi_fifo #(
    .WIDTH (ohbi_pkg::OHBI_WORD_W),
    .DEPTH (ohbi_pkg::OHBI_FIFO_DEPTH)
  ) u_fifo (
    .ref_clk   (ref_clk),
    .reset_n   (!init),
    .in_valid  (push_reg),
    .in_ready  (fifo_ready),
    .in_data   (push_word_reg),
    .out_valid (wr_valid),
    .out_ready (wr_ready),
    .out_data  (wr_word)
  );

  assign bus_ready = fifo_ready;
  assign overflow  = overflow_reg;

  //////////////////////////////////////////////////////////////////////////////
  // Display read pipeline: each data read returns the byte fetched by the
  // previous one, so the first read after a column address is a dummy.
  always_ff @(posedge ref_clk) begin
    if (init) begin
      read_latch_reg <= ohbi_pkg::OHBI_BYTE_RST;
      dummy_reg      <= 1'b1;
      ram_next_reg   <= 1'b0;
    end else begin
      ram_next_reg <= par_read_end && s2_reg.cmd_or_data_sel;
      if (par_read_end && s2_reg.cmd_or_data_sel) begin
        read_latch_reg <= ram_data_in;
      end
      // A column write wins over a read ending in the same cycle.
      if (col_addr_written) begin
        dummy_reg <= 1'b1;
      end else if (par_read_end && s2_reg.cmd_or_data_sel) begin
        dummy_reg <= 1'b0;
      end
    end
  end

  assign ram_next = ram_next_reg;

  // Bus drive: status for cmd_or_data_sel low, latched data for high.
  always_ff @(posedge ref_clk) begin
    if (init) begin
      db_out_reg <= ohbi_pkg::OHBI_BYTE_RST;
      db_oe_reg  <= 1'b0;
    end else begin
      db_oe_reg  <= read_drive;
      // The dummy read returns a fixed byte rather than a stale one.
      db_out_reg <= !s2_reg.cmd_or_data_sel ? status_in
                  : dummy_reg ? ohbi_pkg::OHBI_BYTE_RST
                  : read_latch_reg;
    end
  end

  assign db_out = db_out_reg;
  assign db_oe  = db_oe_reg;

endmodule : ohbi_top

`default_nettype wire

/* ohbi_checker.sv */
// Port checks for the display host bus interface.
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
module ohbi_checker (
  input wire logic                    ref_clk,
  input wire logic                    reset_n,
  input wire logic [1:0]              bus_mode,
  input wire logic                    read_not_write_or_write_strobe_n,
  input wire logic                    cmd_or_data_sel,
  input wire logic                    chip_sel_n,
  input wire logic                    db_oe,
  input wire logic                    ram_next,
  input wire logic                    wr_valid,
  input wire logic                    wr_ready,
  input wire ohbi_pkg::ohbi_word_type wr_word,
  input wire logic                    overflow,
  input wire logic                    init_active
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  // A read is over once the controller is told to advance.
  sequence s_read_done;
    $rose(ram_next);
  endsequence
  // Pin delays come from the two-flop synchronisers plus the output, staging and FIFO registers.
  a_serial_no_read: assert property (bus_mode[1] |-> !db_oe)
    else $error("data pins driven in a serial mode");
  a_oe_cs_low: assert property ($rose(db_oe)
    |-> $past(chip_sel_n, 3) == 1'b0)
    else $error("read answered without chip select");
  a_oe_read_only: assert property ($rose(db_oe)
    |-> read_not_write_or_write_strobe_n)
    else $error("data pins driven during a write");
  a_next_data_only: assert property (s_read_done
    |-> $past(cmd_or_data_sel, 3))
    else $error("address advanced on a status read");
  a_next_one_cycle: assert property (ram_next |=> !ram_next)
    else $error("advance pulse longer than one cycle");
  a_init_clears: assert property (init_active
    |=> !wr_valid && !overflow && !db_oe && !ram_next)
    else $error("init left outputs active");
  a_overflow_holds: assert property (overflow && !init_active
    |=> overflow)
    else $error("overflow cleared without init");
  a_word_holds: assert property (wr_valid && !wr_ready && !init_active
    |=> wr_valid && $stable(wr_word))
    else $error("word changed before it was taken");
  a_take_selected: assert property ($rose(wr_valid)
    |-> $past(chip_sel_n, 4) == 1'b0)
    else $error("word taken without chip select");
endmodule : ohbi_checker

bind ohbi_top ohbi_checker u_chk (.ref_clk, .reset_n, .bus_mode,
  .read_not_write_or_write_strobe_n, .cmd_or_data_sel, .chip_sel_n, .db_oe,
  .ram_next, .wr_valid, .wr_ready, .wr_word, .overflow, .init_active);
`default_nettype wire

/* ohbi_host_model.sv */
// Host microcontroller model that drives the display's bus pins.
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
module ohbi_host_model (
  input  wire logic       ref_clk,
  input  wire logic [7:0] din,
  output logic            pin_a,
  output logic            pin_b,
  output logic            dc,
  output logic            cs_n,
  output logic [7:0]      db
);
  timeunit 1ns;
  timeprecision 1ns;
  // Idle: both 8080 strobes high, chip not selected.
  initial {pin_a, pin_b, dc, cs_n, db} = 12'hd00;
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : cyc
  // Idle strobe levels change in the same cycle as the mode, with the chip deselected, so no false edge.
  task automatic idle(input bit m68);
    pin_a <= !m68;
    pin_b <= !m68;
  endtask : idle
  // Parallel cycle; the 4 cycle minimum spacing keeps the synchronisers happy.
  task automatic par(input bit m68, input bit rd, input logic d,
                     input logic [7:0] v, output logic [7:0] got);
    cs_n <= 1'b0;
    dc <= d;
    db <= rd ? ~db : v; // Released lines show the inverse, not a held value.
    pin_b <= m68 ? rd : 1'b1;
    cyc(4);
    if (m68 || rd) pin_a <= m68;
    else pin_b <= 1'b0;
    cyc(6);
    got = din;
    pin_a <= !m68;
    pin_b <= m68 ? rd : 1'b1;
    cyc(4);
    cs_n <= 1'b1;
    cyc(4);
  endtask : par
  // Serial frame; the link clock stands still low between frames.
  task automatic ser(input bit three, input logic d, input logic [7:0] v);
    logic [8:0] bits;
    bits = {d, v};
    {pin_a, pin_b} <= 2'h0;
    cs_n <= 1'b0;
    dc <= three ? 1'b0 : d;
    for (int i = three ? 8 : 7; i >= 0; i--) begin
      db <= {6'h00, bits[i], 1'b0};
      cyc(4);
      db[0] <= 1'b1;
      cyc(4);
    end
    db[0] <= 1'b0;
    cyc(4);
    cs_n <= 1'b1;
    cyc(4);
  endtask : ser
endmodule : ohbi_host_model
`default_nettype wire

/* oled_host_bus_interface_test.sv */
// Self-checking bench for the display host bus interface.
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
module oled_host_bus_interface_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic                    ref_clk;
  logic                    reset_n = 1'b0;
  logic                    hard_init_n = 1'b1;
  logic [1:0]              bus_mode = 2'h0;
  logic [7:0]              status_in = 8'h00;
  logic [7:0]              ram_data_in = 8'h00;
  logic                    col_addr_written = 1'b0;
  logic                    wr_ready = 1'b1;
  logic                    hold = 1'b0;
  logic                    pin_a, pin_b, dc, cs_n;
  logic [7:0]              db, db_out, db_wire;
  logic                    db_oe, ram_next, wr_valid, bus_ready, overflow;
  logic                    init_active;
  ohbi_pkg::ohbi_word_type wr_word;
  logic [8:0]              expq[$];
  int                      failures = 0;
  int                      compares = 0;
  // The data wire follows whoever drives it.
  assign db_wire = db_oe ? db_out : db;
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  ohbi_host_model host (.ref_clk, .din(db_wire), .pin_a, .pin_b, .dc, .cs_n,
    .db);
  ohbi_top dut (.ref_clk, .reset_n, .hard_init_n, .bus_mode,
    .latch_clk_or_read_strobe_n(pin_a),
    .read_not_write_or_write_strobe_n(pin_b),
    .cmd_or_data_sel(dc), .chip_sel_n(cs_n), .db_in(db_wire), .db_out, .db_oe,
    .status_in, .ram_data_in, .col_addr_written, .ram_next, .wr_valid,
    .wr_ready, .wr_word, .bus_ready, .overflow, .init_active);
  task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic test_done;
    if (failures == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : test_done
  // Consumer stalls at random; the controller advances on request.
  always @(posedge ref_clk) begin
    wr_ready <= hold ? 1'b0 : 1'($urandom_range(1));
    if (ram_next === 1'b1) ram_data_in <= ram_data_in + 8'h01;
    if (reset_n && wr_valid === 1'b1 && wr_ready === 1'b1) begin
      chk(wr_word, expq.size() != 0 ? expq.pop_front() : 9'hxxx);
    end
  end
  task automatic mode(input logic [1:0] m);
    host.idle(m != 2'h0);
    bus_mode <= m;
    repeat (8) @(posedge ref_clk);
  endtask : mode
  // A full FIFO drops the new word, so the model keeps at most 16.
  task automatic wr(input bit ser, input bit three, input logic d);
    logic [7:0] v;
    logic [7:0] g;
    v = 8'($urandom);
    if (expq.size() < ohbi_pkg::OHBI_FIFO_DEPTH) expq.push_back({d, v});
    if (ser) host.ser(three, d, v);
    else host.par(bus_mode[0], 1'b0, d, v, g);
  endtask : wr
  task automatic rd(input logic d, input logic [7:0] e, input bit check);
    logic [7:0] g;
    host.par(bus_mode[0], 1'b1, d, 8'h00, g);
    if (check) chk({1'b0, g}, {1'b0, e});
  endtask : rd
  task automatic drain;
    for (int i = 0; i < 400 && expq.size() != 0; i++) @(posedge ref_clk);
    chk(9'(expq.size()), 9'h000);
    if (expq.size() != 0) test_done;
  endtask : drain
  // Main sequence: both parallel modes, overflow, init, both serial modes.
  initial begin
    logic [7:0] base;
    void'($urandom(9));
    repeat (20) @(posedge ref_clk);
    chk({5'h00, db_oe, wr_valid, overflow, bus_ready}, 9'h001);
    reset_n <= 1'b1;
    repeat (6) @(posedge ref_clk);
    for (int m = 0; m < 2; m++) begin
      mode(2'(m));
      for (int k = 0; k < 4; k++) wr(1'b0, 1'b0, 1'(k));
      status_in <= 8'($urandom);
      @(posedge ref_clk);
      rd(1'b0, status_in, 1'b1);
      ram_data_in <= 8'($urandom);
      col_addr_written <= 1'b1;
      @(posedge ref_clk);
      col_addr_written <= 1'b0;
      base = ram_data_in;
      rd(1'b1, 8'h00, 1'b0);
      rd(1'b1, base, 1'b1);
      rd(1'b1, base + 8'h01, 1'b1);
    end
    mode(2'h0);
    hold <= 1'b1;
    repeat (17) wr(1'b0, 1'b0, 1'b1);
    chk({7'h00, bus_ready, overflow}, 9'h001);
    hold <= 1'b0;
    drain;
    hard_init_n <= 1'b0;
    repeat (6) @(posedge ref_clk);
    chk({7'h00, init_active, overflow}, 9'h002);
    hard_init_n <= 1'b1;
    repeat (6) @(posedge ref_clk);
    for (int m = 2; m < 4; m++) begin
      mode(2'(m));
      for (int k = 0; k < 4; k++) wr(1'b1, m == 2, 1'(k));
      drain;
    end
    test_done;
  end
endmodule : oled_host_bus_interface_test
`default_nettype wire
